// *** design/codec_clock_and_record_config.sv ***
// codec_clock_and_record_config: clock generation settings and record front-end configuration
// Notes on behaviour
// - fractional mode: output equals reference times integer plus numerator over denominator.
// - converter rate is bits 2..0 of the converter control register.
// - engine frame rate four bits at 0x40EB (the strobe decodes only bits 2..0); serial rate three bits at 0x40F8.
// - each rate is core clock over 256 times 1,6,4,3,2,1.5 or 0.5.
// - device drives microphone clock output at rate chosen in clock control.
// - microphone data bypasses ADCs into decimators; only one source feeds them.
// - eight-bit left and right ADC attenuation fields at 0x401A and 0x401B.
// - bit 5 of ADC control enables the DC-removing high-pass filter.
// - one ADC control bit selects oversampling of 64 or 128 for both channels.
// - multiplier source forces core divider to four, giving 256 times base rate.
// - integer mode ignores numerator and denominator.
`timescale 1ns/100ps
`default_nettype none
module codec_clock_and_record_config (
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	input  wire codec_clk_pkg::reg_req_t req,
	output logic [7:0]                   rdata,
	output logic                         rvalid,
	input  wire logic                    mic_data_left,
	input  wire logic                    mic_data_right,
	output logic                         mic_clock_out,
	output codec_clk_pkg::mult_cfg_t     mult_cfg,
	output logic [1:0]                   core_div_sel,
	output logic                         core_clk_src_mult,
	output logic                         core_clk_enable,
	output logic                         tone_enable,
	output logic [7:0]                   tone_gain,
	output logic [7:0]                   mic_supply_mode,
	output logic [1:0]                   decim_src_mic,
	output logic [1:0]                   decim_pdm_bit,
	output logic                         hpf_enable,
	output logic                         osr_128,
	output logic [7:0]                   atten_left,
	output logic [7:0]                   atten_right,
	output logic                         conv_strobe,
	output logic                         engine_strobe,
	output logic                         serial_strobe
);
	typedef enum {MULT_IDLE, MULT_LOAD} mult_state_t;

	logic [7:0]  clk_ctl_q, clk_ctl_d;
	logic [7:0]  dmic_q, dmic_d;
	logic [7:0]  bias_q, bias_d;
	logic [7:0]  conv_q, conv_d;
	logic [7:0]  adc_q, adc_d;
	logic [7:0]  att_l_q, att_l_d;
	logic [7:0]  att_r_q, att_r_d;
	logic [7:0]  eng_q, eng_d;
	logic [7:0]  ser_q, ser_d;
	logic [7:0]  mbuf_q [0:5];
	logic [7:0]  mbuf_d [0:5];
	logic [7:0]  mcur_q [0:5];
	logic [7:0]  mcur_d [0:5];
	logic [2:0]  midx_q, midx_d;
	mult_state_t mst_q, mst_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  mic_l_sync_q, mic_r_sync_q;
	logic [3:0]  mck_cnt_q, mck_cnt_d;
	logic        mck_q, mck_d;
	logic [1:0]  pdm_q, pdm_d;
	logic [3:0]  mck_half;

	// register writes and the six-byte multiplier capture
	always_comb begin
		clk_ctl_d = clk_ctl_q;
		dmic_d    = dmic_q;
		bias_d    = bias_q;
		conv_d    = conv_q;
		adc_d     = adc_q;
		att_l_d   = att_l_q;
		att_r_d   = att_r_q;
		eng_d     = eng_q;
		ser_d     = ser_q;
		mst_d     = mst_q;
		midx_d    = midx_q;
		for (int i = 0; i < 6; i++) begin
			mbuf_d[i] = mbuf_q[i];
			mcur_d[i] = mcur_q[i];
		end
		case (mst_q)
			MULT_IDLE: begin
				if (req.wr && req.addr == codec_clk_pkg::ADDR_FRAC_MULT) begin
					mbuf_d[0] = req.wdata;
					midx_d    = 3'h1;
					mst_d     = MULT_LOAD;
				end
			end
			MULT_LOAD: begin
				// a read or last flag on a cycle without a write, before byte six, abandons the update so a torn word never applies; idle cycles keep the burst open
				if (req.wr) begin
					mbuf_d[midx_q] = req.wdata;
					if (midx_q == 3'(codec_clk_pkg::MULT_BYTES - 1)) begin
						for (int i = 0; i < 5; i++) begin
							mcur_d[i] = mbuf_q[i];
						end
						mcur_d[5] = req.wdata;
						mst_d     = MULT_IDLE;
					end else begin
						midx_d = midx_q + 3'h1;
					end
				end else if (req.last || req.rd) begin
					mst_d = MULT_IDLE;
				end
			end
			default: mst_d = MULT_IDLE;
		endcase
		if (req.wr && mst_q == MULT_IDLE) begin
			if (req.addr == codec_clk_pkg::ADDR_CLOCK_CONTROL) begin
				clk_ctl_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_DMIC_TONE) begin
				dmic_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_BIAS_TONE_EN) begin
				bias_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_CONV_CONTROL_0) begin
				conv_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_ADC_CONTROL) begin
				adc_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_LEFT_ADC_ATTEN) begin
				att_l_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_RIGHT_ADC_ATTEN) begin
				att_r_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_ENGINE_RATE) begin
				eng_d = req.wdata;
			end else if (req.addr == codec_clk_pkg::ADDR_SERIAL_RATE) begin
				ser_d = req.wdata;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_ctl_q <= codec_clk_pkg::RST_CLOCK_CONTROL;
			dmic_q    <= codec_clk_pkg::RST_ZERO;
			bias_q    <= codec_clk_pkg::RST_ZERO;
			conv_q    <= codec_clk_pkg::RST_ZERO;
			adc_q     <= codec_clk_pkg::RST_ADC_CONTROL;
			att_l_q   <= codec_clk_pkg::RST_ZERO;
			att_r_q   <= codec_clk_pkg::RST_ZERO;
			eng_q     <= codec_clk_pkg::RST_ZERO;
			ser_q     <= codec_clk_pkg::RST_ZERO;
			mst_q     <= MULT_IDLE;
			midx_q    <= 3'h0;
			for (int i = 0; i < 6; i++) begin
				mbuf_q[i] <= 8'h00;
				mcur_q[i] <= 8'h00;
			end
		end else begin
			clk_ctl_q <= clk_ctl_d;
			dmic_q    <= dmic_d;
			bias_q    <= bias_d;
			conv_q    <= conv_d;
			adc_q     <= adc_d;
			att_l_q   <= att_l_d;
			att_r_q   <= att_r_d;
			eng_q     <= eng_d;
			ser_q     <= ser_d;
			mst_q     <= mst_d;
			midx_q    <= midx_d;
			for (int i = 0; i < 6; i++) begin
				mbuf_q[i] <= mbuf_d[i];
				mcur_q[i] <= mcur_d[i];
			end
		end
	end

	// read path; unmapped addresses read zero
	always_comb begin
		rvalid_d = req.rd;
		rdata_d  = 8'h00;
		if (req.addr == codec_clk_pkg::ADDR_CLOCK_CONTROL) begin
			rdata_d = clk_ctl_q;
		end else if (req.addr == codec_clk_pkg::ADDR_DMIC_TONE) begin
			rdata_d = dmic_q;
		end else if (req.addr == codec_clk_pkg::ADDR_BIAS_TONE_EN) begin
			rdata_d = bias_q;
		end else if (req.addr == codec_clk_pkg::ADDR_CONV_CONTROL_0) begin
			rdata_d = conv_q;
		end else if (req.addr == codec_clk_pkg::ADDR_ADC_CONTROL) begin
			rdata_d = adc_q;
		end else if (req.addr == codec_clk_pkg::ADDR_LEFT_ADC_ATTEN) begin
			rdata_d = att_l_q;
		end else if (req.addr == codec_clk_pkg::ADDR_RIGHT_ADC_ATTEN) begin
			rdata_d = att_r_q;
		end else if (req.addr == codec_clk_pkg::ADDR_ENGINE_RATE) begin
			rdata_d = eng_q;
		end else if (req.addr == codec_clk_pkg::ADDR_SERIAL_RATE) begin
			rdata_d = ser_q;
		end else if (req.addr >= codec_clk_pkg::ADDR_FRAC_MULT &&
				req.addr < codec_clk_pkg::ADDR_FRAC_MULT + 16'h0006) begin
			rdata_d = mcur_q[3'(req.addr - codec_clk_pkg::ADDR_FRAC_MULT)];
		end
		if (!req.rd) begin
			rdata_d = rdata_q;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// microphone data pins come from outside, two flops before use
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mic_l_sync_q <= 2'b00;
			mic_r_sync_q <= 2'b00;
		end else begin
			mic_l_sync_q <= {mic_l_sync_q[0], mic_data_left};
			mic_r_sync_q <= {mic_r_sync_q[0], mic_data_right};
		end
	end

	// microphone clock: half period of (sel+1) core cycles; samples taken on rising edge
	always_comb begin
		mck_half  = {2'b00, clk_ctl_q[codec_clk_pkg::MIC_CLK_LSB +: 2]};
		mck_cnt_d = mck_cnt_q + 4'h1;
		mck_d     = mck_q;
		pdm_d     = pdm_q;
		if (!clk_ctl_q[codec_clk_pkg::CLK_EN_BIT]) begin
			mck_cnt_d = 4'h0;
			mck_d     = 1'b0;
		end else if (mck_cnt_q >= mck_half) begin
			mck_cnt_d = 4'h0;
			mck_d     = ~mck_q;
			if (!mck_q) begin
				pdm_d = {mic_r_sync_q[1], mic_l_sync_q[1]};
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mck_cnt_q <= 4'h0;
			mck_q     <= 1'b0;
			pdm_q     <= 2'b00;
		end else begin
			mck_cnt_q <= mck_cnt_d;
			mck_q     <= mck_d;
			pdm_q     <= pdm_d;
		end
	end

	// sample-rate strobes for converter, engine and serial port
	rate_strobe u_conv (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (clk_ctl_q[codec_clk_pkg::CLK_EN_BIT]),
		.sel      ({1'b0, conv_q[2:0]}),
		.strobe   (conv_strobe)
	);
	rate_strobe u_eng (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (clk_ctl_q[codec_clk_pkg::CLK_EN_BIT]),
		.sel      (eng_q[3:0]),
		.strobe   (engine_strobe)
	);
	rate_strobe u_ser (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (clk_ctl_q[codec_clk_pkg::CLK_EN_BIT]),
		.sel      ({1'b0, ser_q[2:0]}),
		.strobe   (serial_strobe)
	);

	// multiplier settings; divider of zero is treated as one
	always_comb begin
		mult_cfg.input_div    = {8'h00, mcur_q[4][6:3] == 4'h0 ? 4'h1 : mcur_q[4][6:3], 4'h0} >> 4;
		mult_cfg.integer_part = {12'h000, mcur_q[4][2:0], 1'b0} >> 1;
		mult_cfg.fractional   = mcur_q[5][codec_clk_pkg::MULT_FRAC_BIT];
		mult_cfg.enable       = mcur_q[5][codec_clk_pkg::MULT_EN_BIT];
		mult_cfg.numerator    = mult_cfg.fractional ? {mcur_q[2], mcur_q[3]} : 16'h0000;
		mult_cfg.denominator  = mult_cfg.fractional ? {mcur_q[0], mcur_q[1]} : 16'h0001;
	end

	assign core_clk_src_mult = clk_ctl_q[codec_clk_pkg::CLK_SRC_BIT];
	assign core_div_sel      = core_clk_src_mult ? 2'b11 : clk_ctl_q[codec_clk_pkg::CLK_RATIO_LSB +: 2];
	assign core_clk_enable   = clk_ctl_q[codec_clk_pkg::CLK_EN_BIT];
	assign tone_enable       = bias_q[0];
	assign tone_gain         = dmic_q;
	assign mic_supply_mode   = bias_q;
	assign mic_clock_out     = mck_q;
	// microphone selection takes the decimator away from the ADC on that channel
	assign decim_src_mic     = {dmic_q[codec_clk_pkg::DMIC_RIGHT_BIT], dmic_q[codec_clk_pkg::DMIC_LEFT_BIT]};
	assign decim_pdm_bit     = pdm_q & decim_src_mic;
	assign hpf_enable        = adc_q[codec_clk_pkg::HPF_BIT];
	assign osr_128           = adc_q[codec_clk_pkg::OSR_BIT];
	assign atten_left        = att_l_q;
	assign atten_right       = att_r_q;
	assign rdata             = rdata_q;
	assign rvalid            = rvalid_q;
endmodule
`default_nettype wire

// *** shared/codec_clk_pkg.sv ***
// package: register map, field positions, reset values and carrier types for the codec clock block
package codec_clk_pkg;
	localparam logic [15:0] ADDR_CLOCK_CONTROL   = 16'h4000;
	localparam logic [15:0] ADDR_FRAC_MULT       = 16'h4002;
	localparam logic [15:0] ADDR_DMIC_TONE       = 16'h4008;
	localparam logic [15:0] ADDR_BIAS_TONE_EN    = 16'h4010;
	localparam logic [15:0] ADDR_CONV_CONTROL_0  = 16'h4017;
	localparam logic [15:0] ADDR_ADC_CONTROL     = 16'h4019;
	localparam logic [15:0] ADDR_LEFT_ADC_ATTEN  = 16'h401A;
	localparam logic [15:0] ADDR_RIGHT_ADC_ATTEN = 16'h401B;
	localparam logic [15:0] ADDR_ENGINE_RATE     = 16'h40EB;
	localparam logic [15:0] ADDR_SERIAL_RATE     = 16'h40F8;
	localparam int          MULT_BYTES           = 6;
	// clock_control fields
	localparam int CLK_EN_BIT     = 0;
	localparam int CLK_RATIO_LSB  = 1;
	localparam int CLK_SRC_BIT    = 3;
	localparam int MIC_CLK_LSB    = 4;
	// dmic_tone_control fields
	localparam int DMIC_LEFT_BIT  = 0;
	localparam int DMIC_RIGHT_BIT = 1;
	// adc_control fields
	localparam int ADC_EN_BIT     = 0;
	localparam int OSR_BIT        = 4;
	localparam int HPF_BIT        = 5;
	// multiplier byte 5 fields
	localparam int MULT_FRAC_BIT  = 1;
	localparam int MULT_EN_BIT    = 0;
	// reset values
	localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
	localparam logic [7:0] RST_ADC_CONTROL   = 8'h10;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	// core clock frequency for derived counts
	localparam int CORE_CLK_MHZ = 40;
	localparam int FS_BASE_DIV  = 256;
	// rate scale encodings: /1 /6 /4 /3 /2 /1.5 /0.5 expressed in half-steps of 256
	localparam logic [3:0] RATE_HALVES [0:7] = '{4'h2, 4'hC, 4'h8, 4'h6, 4'h4, 4'h3, 4'h1, 4'h2};

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
		logic        last;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] input_div;
		logic [15:0] integer_part;
		logic [15:0] numerator;
		logic [15:0] denominator;
		logic        fractional;
		logic        enable;
	} mult_cfg_t;
endpackage

// *** design/rate_strobe.sv ***
// rate_strobe: emits one pulse per sample period of a core-clock-divided sampling rate
`timescale 1ns/100ps
`default_nettype none
module rate_strobe (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [3:0] sel,
	output logic            strobe
);
	logic [10:0] cnt_q;
	logic [10:0] cnt_d;
	logic [10:0] limit;
	logic        strobe_q;
	logic        strobe_d;

	// period in core cycles is 128 times the half-step count from the scale table
	always_comb begin
		limit    = {codec_clk_pkg::RATE_HALVES[sel[2:0]], 7'h00} - 11'h001;
		cnt_d    = cnt_q;
		strobe_d = 1'b0;
		if (!run) begin
			cnt_d = 11'h000;
		end else if (cnt_q >= limit) begin
			cnt_d    = 11'h000;
			strobe_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 11'h001;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q    <= 11'h000;
			strobe_q <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			strobe_q <= strobe_d;
		end
	end

	assign strobe = strobe_q;
endmodule
`default_nettype wire

// *** tb/codec_clk_properties.sv ***
// checker: port relations of the codec clock and record configuration block
`timescale 1ns/100ps
`default_nettype none
module codec_clk_properties (
	input wire logic                     core_clk,
	input wire logic                     sys_rst,
	input wire codec_clk_pkg::reg_req_t  req,
	input wire logic [7:0]               rdata,
	input wire logic                     rvalid,
	input wire logic                     mic_clock_out,
	input wire codec_clk_pkg::mult_cfg_t mult_cfg,
	input wire logic [1:0]               core_div_sel,
	input wire logic                     core_clk_src_mult,
	input wire logic                     core_clk_enable,
	input wire logic [1:0]               decim_src_mic,
	input wire logic [1:0]               decim_pdm_bit,
	input wire logic                     hpf_enable,
	input wire logic                     osr_128,
	input wire logic [7:0]               atten_left,
	input wire logic [7:0]               atten_right,
	input wire logic                     conv_strobe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// a plain read, no write in the same cycle
	sequence rd_s(a);
		req.rd && !req.wr && req.addr == a;
	endsequence
	AST_RVALID: assert property (req.rd |=> rvalid)
		else $error("read without answer");
	AST_NO_RVALID: assert property (!req.rd |=> !rvalid)
		else $error("answer without read");
	AST_DIV4: assert property (core_clk_src_mult |-> core_div_sel == 2'h3)
		else $error("multiplier source without divide by four");
	AST_MIC_OFF: assert property (!core_clk_enable && !$past(core_clk_enable) |-> !mic_clock_out)
		else $error("mic clock runs while disabled");
	// pdm bits may only move on a mic clock rise or a change of source
	AST_MASK: assert property ($changed(decim_pdm_bit) |-> ($rose(mic_clock_out) || $changed(decim_src_mic)) && (decim_pdm_bit & ~decim_src_mic) == 2'h0)
		else $error("pdm bit moved off the mic clock or from unselected mic");
	AST_INT_MODE: assert property (!mult_cfg.fractional |-> mult_cfg.numerator == 16'h0000 && mult_cfg.denominator == 16'h0001)
		else $error("fraction kept in integer mode");
	AST_MULT_WR: assert property (!$stable(mult_cfg) |-> $past(req.wr))
		else $error("multiplier changed without write");
	AST_STROBE: assert property (conv_strobe |=> !conv_strobe [*8])
		else $error("converter strobe too close");
	AST_ATTEN: assert property (rd_s(16'h401A) |=> rdata == $past(atten_left))
		else $error("left attenuation readback differs");
	AST_ATTEN_R: assert property (rd_s(16'h401B) |=> rdata == $past(atten_right))
		else $error("right attenuation readback differs");
	AST_ADC_CTL: assert property (rd_s(16'h4019) |=> rdata[5] == $past(hpf_enable) && rdata[4] == $past(osr_128))
		else $error("adc control readback differs");
	// main scenarios reached
	cover property (rvalid);
	cover property (conv_strobe);
	cover property ($rose(mult_cfg.fractional));
	cover property (core_clk_src_mult);
endmodule
bind codec_clock_and_record_config codec_clk_properties chk_i (.*);
`default_nettype wire

// *** tb/pdm_mic_model.sv ***
// partner: two pdm microphones clocked by the block's microphone clock
`timescale 1ns/100ps
`default_nettype none
module pdm_mic_model (
	input  wire logic mic_clk,
	output logic      data_left,
	output logic      data_right
);
	logic [3:0] pat_q = 4'h0;
	// new bit after the falling edge, settled for the rising-edge latch
	always @(negedge mic_clk) begin
		pat_q <= pat_q + 4'h1;
	end
	assign data_left  = pat_q[0];
	assign data_right = pat_q[1] ^ pat_q[0];
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: register traffic, multiplier bursts, rate strobes and microphone clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic                     core_clk, sys_rst, rvalid, mic_clock_out;
	logic                     mic_data_left, mic_data_right, core_clk_src_mult, core_clk_enable;
	logic                     tone_enable, hpf_enable, osr_128;
	logic                     conv_strobe, engine_strobe, serial_strobe;
	logic [7:0]               rdata, tone_gain, mic_supply_mode, atten_left, atten_right;
	logic [1:0]               core_div_sel, decim_src_mic, decim_pdm_bit, seen;
	logic [3:0]               strb;
	codec_clk_pkg::reg_req_t  req;
	codec_clk_pkg::mult_cfg_t mult_cfg;
	int                       failures, num_checks;
	localparam logic [15:0] ADR [0:8] = '{16'h4001, 16'h4008, 16'h4010, 16'h4017, 16'h4019,
		16'h401A, 16'h401B, 16'h40EB, 16'h40F8};
	localparam logic [7:0] RST [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] PAT [0:8] = '{8'h5A, 8'hA6, 8'h3D, 8'h05, 8'h21, 8'h9F, 8'hC3, 8'h0E, 8'h06};
	localparam int HALVES [0:6] = '{2, 12, 8, 6, 4, 3, 1};
	assign strb = {mic_clock_out, serial_strobe, engine_strobe, conv_strobe};
	codec_clock_and_record_config uut (.*);
	pdm_mic_model mic (.mic_clk(mic_clock_out), .data_left(mic_data_left), .data_right(mic_data_right));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic end_sim;
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [65:0] seen_v, input logic [65:0] exp);
		num_checks++;
		if (seen_v !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen_v, exp);
		end
	endtask
	// tasks start and end on a rising edge; inputs move 1 ns after it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		#1 req = '{a, d, 1'b1, 1'b0, 1'b0};
		@(posedge core_clk);
		#1 req = '0;
		@(posedge core_clk);
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		#1 req = '{a, 8'h00, 1'b0, 1'b1, 1'b0};
		@(posedge core_clk);
		#1 req = '0;
		chk(rvalid, 1'b1);
		chk(rdata, exp);
		@(posedge core_clk);
	endtask
	// back-to-back bytes; a short count leaves the burst open for abandoning
	task automatic mult(input logic [47:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			#1 req = '{16'h4002, b[47-8*i -: 8], 1'b1, 1'b0, i == 5};
			@(posedge core_clk);
		end
		#1 req = '0;
		@(posedge core_clk);
	endtask
	// rising edge to rising edge; bounded so a dead strobe cannot hang the run
	task automatic period(input int k, input int exp);
		int c;
		logic p;
		#1;
		for (int n = 0; n < 2; n++) begin
			c = 0;
			do begin
				p = strb[k];
				@(posedge core_clk);
				#1;
				c++;
			end while (!(strb[k] === 1'b1 && p === 1'b0) && c < 4000);
		end
		chk(c, exp);
		if (c >= 4000)
			end_sim();
		@(posedge core_clk);
	endtask
	initial begin
		failures = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		req = '0;
		repeat (2) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		@(posedge core_clk);
		chk(osr_128, 1'b1);
		chk(mult_cfg, {16'h0001, 16'h0000, 16'h0000, 16'h0001, 2'h0});
		foreach (ADR[i]) rdchk(ADR[i], RST[i]);
		foreach (ADR[i]) wr(ADR[i], PAT[i]);
		foreach (ADR[i]) rdchk(ADR[i], i == 0 ? 8'h00 : PAT[i]);
		chk({tone_gain, tone_enable, mic_supply_mode}, {8'hA6, 1'b1, 8'h3D});
		chk({atten_left, atten_right}, {8'h9F, 8'hC3});
		chk({hpf_enable, osr_128, decim_src_mic}, {1'b1, 1'b0, 2'h2});
		wr(16'h4019, 8'h10);
		chk({hpf_enable, osr_128}, {1'b0, 1'b1});
		wr(16'h4000, 8'h08);
		chk({core_clk_src_mult, core_div_sel}, {1'b1, 2'h3});
		wr(16'h4000, 8'h04);
		chk({core_clk_src_mult, core_div_sel}, {1'b0, 2'h2});
		rdchk(16'h4000, 8'h04);
		// microphone clock, period twice the selected half period
		for (int s = 0; s < 4; s++) begin
			wr(16'h4000, {2'h0, s[1:0], 4'h1});
			period(3, 2 * (s + 1));
		end
		wr(16'h4008, 8'h01);
		seen = 2'h0;
		repeat (40) begin
			@(posedge core_clk);
			seen = seen | decim_pdm_bit;
		end
		chk(seen, 2'h1);
		for (int s = 0; s < 7; s++) begin
			wr(16'h4017, s[7:0]);
			period(0, 128 * HALVES[s]);
		end
		wr(16'h40EB, 8'h08);
		period(1, 256);
		wr(16'h40F8, 8'h06);
		period(2, 128);
		mult(48'h007D_000C_0C03, 6);
		chk(mult_cfg, {16'h0001, 16'h0004, 16'h000C, 16'h007D, 2'h3});
		mult(48'h0271_01DD_0B03, 6);
		chk(mult_cfg, {16'h0001, 16'h0003, 16'h01DD, 16'h0271, 2'h3});
		mult(48'h007D_000C_0C03, 3);
		rdchk(16'h4002, 8'h02);
		chk(mult_cfg.denominator, 16'h0271);
		mult(48'h007D_000C_1701, 6);
		chk(mult_cfg, {16'h0002, 16'h0007, 16'h0000, 16'h0001, 2'h1});
		// core clock off: mic clock must drop and stay low, not freeze high
		wr(16'h4000, 8'h30);
		rdchk(16'h4000, 8'h30);
		seen = 2'h0;
		repeat (10) begin
			@(posedge core_clk);
			seen = seen | {core_clk_enable, mic_clock_out};
		end
		chk(seen, 2'h0);
		end_sim();
	end
endmodule
`default_nettype wire
